/* File: pkg/vll_pkg.sv */
// Shared constants and types for the velocity loop limiter and window block
`default_nettype none
package vll_pkg;

    // Widths
    localparam int VEL_W = 32;
    localparam int IDX_W = 16;
    localparam int TIME_W = 16;
    localparam int WIDE_W = 48;

    // Dictionary indices
    localparam logic [15:0] IDX_MAX_ACCEL = 16'h2100;
    localparam logic [15:0] IDX_MAX_DECEL = 16'h2101;
    localparam logic [15:0] IDX_ESTOP_DECEL = 16'h2102;
    localparam logic [15:0] IDX_MAX_LIMIT = 16'h2103;
    localparam logic [15:0] IDX_TRACK_WINDOW = 16'h2104;
    localparam logic [15:0] IDX_TRACK_TIME = 16'h2105;
    localparam logic [15:0] IDX_LIMITED_VEL = 16'h2230;
    localparam logic [15:0] IDX_LOAD_VEL = 16'h2231;
    localparam logic [15:0] IDX_UNFILT_VEL = 16'h2232;
    localparam logic [15:0] IDX_PROG_VEL = 16'h2341;
    localparam logic [15:0] IDX_PRIMARY_VEL = 16'h6069;
    localparam logic [15:0] IDX_ACTUAL_VEL = 16'h606c;
    localparam logic [15:0] IDX_PROF_WINDOW = 16'h606d;
    localparam logic [15:0] IDX_PROF_TIME = 16'h606e;

    // Reset values
    localparam logic [31:0] RST_MAX_ACCEL = 32'h0000_03e8;
    localparam logic [31:0] RST_MAX_DECEL = 32'h0000_03e8;
    localparam logic [31:0] RST_ESTOP_DECEL = 32'h0000_07d0;
    localparam logic [31:0] RST_MAX_LIMIT = 32'h1dcd_6500;
    localparam logic [31:0] RST_TRACK_WINDOW = 32'h0000_03e8;
    localparam logic [15:0] RST_TRACK_TIME = 16'h000a;
    localparam logic [31:0] RST_PROG_VEL = 32'h0000_0000;

    // Field layout of the 16-bit aliased objects
    localparam int ALIAS16_MSB = 15;

    // Rate unit 1000 counts/s^2 into 0.1 counts/s per second
    localparam logic [47:0] RATE_SCALE = 48'h0000_0000_2710;

    // Timing
    localparam int MS_NS = 1000000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int SERVO_HZ = 3000;

    // Source of the velocity command
    typedef enum logic [1:0] {
        VLL_SRC_EXTERNAL,
        VLL_SRC_POSITION,
        VLL_SRC_PROGRAMMED
    } vll_src_e;

    // Object access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [31:0] data;
    } vll_obj_req_s;

    // Object access answer
    typedef struct packed {
        logic valid;
        logic err;
        logic [31:0] data;
    } vll_obj_rsp_s;

endpackage
`default_nettype wire

/* File: src/vll_rate_clamp.sv */
// One servo step of rate limiting followed by the magnitude clamp
`default_nettype none
module vll_rate_clamp #(
    parameter int W = 48
) (
    // Present and wanted command
    input wire logic signed [W-1:0] current,
    input wire logic signed [W-1:0] target,
    // Per-tick steps and limit
    input wire logic [W-1:0] accStep,
    input wire logic [W-1:0] decStep,
    input wire logic [W-1:0] maxLimit,
    // Result
    output logic signed [W-1:0] result
);

    logic signed [W-1:0] delta;
    logic signed [W-1:0] stepped;
    logic [W-1:0] step;
    logic [W-1:0] absDelta;
    logic growing;

    always_comb begin
        delta = target - current;
        absDelta = delta[W-1] ? W'(-delta) : W'(delta);
        // [RQ2] Speed rising
        growing = (current >= 0 && delta > 0) || (current <= 0 && delta < 0);
        // [RQ3] Speed falling
        step = growing ? accStep : decStep;
        // [RQ15] Rate first
        if (absDelta <= step) begin
            stepped = target;
        end else if (delta[W-1]) begin
            stepped = current - $signed(step);
        end else begin
            stepped = current + $signed(step);
        end
        // [RQ6] Magnitude clamp
        if (stepped > $signed(maxLimit)) begin
            result = $signed(maxLimit);
        end else if (stepped < -$signed(maxLimit)) begin
            result = -$signed(maxLimit);
        end else begin
            result = stepped;
        end
    end

endmodule // vll_rate_clamp
`default_nettype wire

/* File: src/vll_velocity_limiter.sv */
// Velocity command limiter, tracking window and velocity objects
`default_nettype none
// How it works
// [RQ1] The actual-velocity object reads the same motor velocity as the primary one.
// [RQ2] Acceleration limit applies only while commanded speed magnitude rises.
// [RQ3] Deceleration limit applies only while commanded speed magnitude falls.
// [RQ4] An active stop ramps the command to zero at the stop deceleration.
// [RQ5] With the position loop driving, an active stop uses the abort acceleration.
// [RQ6] The command from any source is clamped to the maximum velocity magnitude.
// [RQ7] The window bit sets as soon as the velocity error exceeds the window.
// [RQ8] The window bit clears only after the error stays inside for the hold time.
// [RQ9] The 16-bit and 32-bit window objects share one value.
// [RQ10] The two tracking-time objects share one millisecond value.
// [RQ11] Limited velocity is the command after limiter, clamp and filter.
// [RQ12] Actual velocity is the motor encoder; load velocity has its own object.
// [RQ13] In programmed velocity mode the command is the programmed-velocity object.
// [RQ14] Position modes feed the position loop output as the command.
// [RQ15] Rate limit, then clamp, then filter, once per servo tick.
module vll_velocity_limiter #(
    parameter int MS_CYCLES = vll_pkg::CYCLES_PER_MS,
    parameter int SERVO_RATE_HZ = vll_pkg::SERVO_HZ,
    parameter int FILT_SHIFT = 0
) (
    // Clock and control
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Servo update
    input wire logic servoTick,
    input wire vll_pkg::vll_src_e cmdSource,
    input wire logic stopActive,
    // Command sources and abort acceleration
    input wire logic signed [31:0] positionLoopVel,
    input wire logic signed [31:0] externalVel,
    input wire logic [31:0] abortAccel,
    // Encoder velocities
    input wire logic signed [31:0] motorVel,
    input wire logic signed [31:0] unfilteredMotorVel,
    input wire logic signed [31:0] loadVel,
    // Object access
    input wire vll_pkg::vll_obj_req_s objReq,
    output vll_pkg::vll_obj_rsp_s objRsp,
    // Results
    output logic signed [31:0] limitedVelocity,
    output logic velWindowBit
);

    localparam int W = vll_pkg::WIDE_W;
    localparam int CNT_W = $clog2(MS_CYCLES + 1);

    // Rate in 1000 counts/s^2 to 0.1 counts/s per tick
    function automatic logic [W-1:0] stepFromRate(input logic [31:0] rate);
        logic [W-1:0] scaled;
        scaled = W'(rate) * vll_pkg::RATE_SCALE;
        return scaled / W'(SERVO_RATE_HZ);
    endfunction

    function automatic logic signed [W-1:0] widen(input logic signed [31:0] v);
        return W'(v);
    endfunction

    // Dictionary storage
    logic [31:0] velMaxAccel, next_velMaxAccel;
    logic [31:0] velMaxDecel, next_velMaxDecel;
    logic [31:0] velEstopDecel, next_velEstopDecel;
    logic [31:0] velMaxLimit, next_velMaxLimit;
    logic [31:0] velTrackWindow, next_velTrackWindow;
    logic [15:0] velTrackTime, next_velTrackTime;
    logic [31:0] programmedVelocityCmd, next_programmedVelocityCmd;
    vll_pkg::vll_obj_rsp_s next_objRsp;

    always_comb begin
        next_velMaxAccel = velMaxAccel;
        next_velMaxDecel = velMaxDecel;
        next_velEstopDecel = velEstopDecel;
        next_velMaxLimit = velMaxLimit;
        next_velTrackWindow = velTrackWindow;
        next_velTrackTime = velTrackTime;
        next_programmedVelocityCmd = programmedVelocityCmd;
        next_objRsp = '0;
        if (objReq.wr) begin
            next_objRsp.valid = 1'b1;
            case (objReq.index)
                vll_pkg::IDX_MAX_ACCEL: next_velMaxAccel = objReq.data;
                vll_pkg::IDX_MAX_DECEL: next_velMaxDecel = objReq.data;
                vll_pkg::IDX_ESTOP_DECEL: next_velEstopDecel = objReq.data;
                vll_pkg::IDX_MAX_LIMIT: next_velMaxLimit = objReq.data;
                // [RQ9] Shared window value
                vll_pkg::IDX_TRACK_WINDOW: next_velTrackWindow = objReq.data;
                vll_pkg::IDX_PROF_WINDOW: begin
                    next_velTrackWindow = {16'h0000, objReq.data[vll_pkg::ALIAS16_MSB:0]};
                end
                // [RQ10] Shared hold time
                vll_pkg::IDX_TRACK_TIME,
                vll_pkg::IDX_PROF_TIME: begin
                    next_velTrackTime = objReq.data[vll_pkg::ALIAS16_MSB:0];
                end
                vll_pkg::IDX_PROG_VEL: next_programmedVelocityCmd = objReq.data;
                default: next_objRsp.err = 1'b1;
            endcase
        end else if (objReq.rd) begin
            next_objRsp.valid = 1'b1;
            case (objReq.index)
                vll_pkg::IDX_MAX_ACCEL: next_objRsp.data = velMaxAccel;
                vll_pkg::IDX_MAX_DECEL: next_objRsp.data = velMaxDecel;
                vll_pkg::IDX_ESTOP_DECEL: next_objRsp.data = velEstopDecel;
                vll_pkg::IDX_MAX_LIMIT: next_objRsp.data = velMaxLimit;
                vll_pkg::IDX_TRACK_WINDOW: next_objRsp.data = velTrackWindow;
                // [RQ9] Low half of the shared window
                vll_pkg::IDX_PROF_WINDOW: begin
                    next_objRsp.data = {16'h0000, velTrackWindow[vll_pkg::ALIAS16_MSB:0]};
                end
                vll_pkg::IDX_TRACK_TIME,
                vll_pkg::IDX_PROF_TIME: next_objRsp.data = {16'h0000, velTrackTime};
                // [RQ11] Final command
                vll_pkg::IDX_LIMITED_VEL: next_objRsp.data = limitedVelocity;
                // [RQ12] Load encoder apart
                vll_pkg::IDX_LOAD_VEL: next_objRsp.data = loadVel;
                vll_pkg::IDX_UNFILT_VEL: next_objRsp.data = unfilteredMotorVel;
                vll_pkg::IDX_PROG_VEL: next_objRsp.data = programmedVelocityCmd;
                // [RQ1] Same motor velocity
                vll_pkg::IDX_PRIMARY_VEL,
                vll_pkg::IDX_ACTUAL_VEL: next_objRsp.data = motorVel;
                default: next_objRsp.err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            velMaxAccel <= vll_pkg::RST_MAX_ACCEL;
            velMaxDecel <= vll_pkg::RST_MAX_DECEL;
            velEstopDecel <= vll_pkg::RST_ESTOP_DECEL;
            velMaxLimit <= vll_pkg::RST_MAX_LIMIT;
            velTrackWindow <= vll_pkg::RST_TRACK_WINDOW;
            velTrackTime <= vll_pkg::RST_TRACK_TIME;
            programmedVelocityCmd <= vll_pkg::RST_PROG_VEL;
            objRsp <= '0;
        end else if (ce) begin
            velMaxAccel <= next_velMaxAccel;
            velMaxDecel <= next_velMaxDecel;
            velEstopDecel <= next_velEstopDecel;
            velMaxLimit <= next_velMaxLimit;
            velTrackWindow <= next_velTrackWindow;
            velTrackTime <= next_velTrackTime;
            programmedVelocityCmd <= next_programmedVelocityCmd;
            objRsp <= next_objRsp;
        end
    end

    // Command path
    logic signed [W-1:0] rampState, next_rampState;
    logic signed [W-1:0] filtState, next_filtState;
    logic signed [31:0] next_limitedVelocity;
    logic signed [W-1:0] target;
    logic [W-1:0] accStep;
    logic [W-1:0] decStep;
    logic signed [W-1:0] stepResult;
    logic positionDriven;

    always_comb begin
        positionDriven = (cmdSource == vll_pkg::VLL_SRC_POSITION);
        case (cmdSource)
            // [RQ14] Position loop output
            vll_pkg::VLL_SRC_POSITION: target = widen(positionLoopVel);
            // [RQ13] Programmed velocity
            vll_pkg::VLL_SRC_PROGRAMMED: target = widen(programmedVelocityCmd);
            vll_pkg::VLL_SRC_EXTERNAL: target = widen(externalVel);
            default: target = widen(externalVel);
        endcase
        accStep = stepFromRate(velMaxAccel);
        decStep = stepFromRate(velMaxDecel);
        if (stopActive) begin
            target = '0;
            if (positionDriven) begin
                // [RQ5] Abort acceleration
                decStep = stepFromRate(abortAccel);
            end else begin
                // [RQ4] Stop deceleration
                decStep = stepFromRate(velEstopDecel);
            end
            accStep = decStep;
        end
    end

    vll_rate_clamp #(
        .W(W)
    ) u_rate_clamp (
        .current(rampState),
        .target(target),
        .accStep(accStep),
        .decStep(decStep),
        .maxLimit(W'(velMaxLimit)),
        .result(stepResult)
    );

    always_comb begin
        next_rampState = rampState;
        next_filtState = filtState;
        next_limitedVelocity = limitedVelocity;
        // [RQ15] Once per tick, filter last
        if (servoTick) begin
            next_rampState = stepResult;
            next_filtState = filtState + ((stepResult - filtState) >>> FILT_SHIFT);
            // [RQ11] Published command
            next_limitedVelocity = next_filtState[31:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rampState <= '0;
            filtState <= '0;
            limitedVelocity <= '0;
        end else if (ce) begin
            rampState <= next_rampState;
            filtState <= next_filtState;
            limitedVelocity <= next_limitedVelocity;
        end
    end

    // Tracking window
    logic [CNT_W-1:0] msPrescale, next_msPrescale;
    logic [15:0] msInside, next_msInside;
    logic next_velWindowBit;
    logic signed [W-1:0] velError;
    logic [W-1:0] absError;

    always_comb begin
        // [RQ12] Motor encoder closes the loop
        velError = widen(limitedVelocity) - widen(motorVel);
        absError = velError[W-1] ? W'(-velError) : W'(velError);
        next_msPrescale = msPrescale;
        next_msInside = msInside;
        next_velWindowBit = velWindowBit;
        if (absError > W'(velTrackWindow)) begin
            // [RQ7] Set at once
            next_velWindowBit = 1'b1;
            next_msPrescale = '0;
            next_msInside = '0;
        end else if (velWindowBit) begin
            // [RQ8] Clear after hold time
            if (msInside >= velTrackTime) begin
                next_velWindowBit = 1'b0;
            end else if (msPrescale == CNT_W'(MS_CYCLES - 1)) begin
                next_msPrescale = '0;
                next_msInside = msInside + 16'h0001;
            end else begin
                next_msPrescale = msPrescale + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            msPrescale <= '0;
            msInside <= '0;
            velWindowBit <= 1'b0;
        end else if (ce) begin
            msPrescale <= next_msPrescale;
            msInside <= next_msInside;
            velWindowBit <= next_velWindowBit;
        end
    end

endmodule // vll_velocity_limiter
`default_nettype wire

/* File: test/vll_velocity_limiter_monitor.sv */
// Assertion checker for the object bus, servo path and window bit
`default_nettype none
module vll_velocity_limiter_monitor (
    // Clock and control
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic servoTick,
    // Observed values
    input wire logic signed [31:0] motorVel,
    input wire logic signed [31:0] loadVel,
    input wire vll_pkg::vll_obj_req_s objReq,
    input wire vll_pkg::vll_obj_rsp_s objRsp,
    input wire logic signed [31:0] limitedVelocity,
    input wire logic velWindowBit
);
    logic [31:0] win, next_win;
    logic [32:0] diff, absDiff;
    logic req;
    assign req = ce && (objReq.wr || objReq.rd);
    assign diff = {limitedVelocity[31], limitedVelocity} - {motorVel[31], motorVel};
    assign absDiff = diff[32] ? -diff : diff;
    // Shadow of the shared window value
    always_comb begin
        next_win = win;
        if (ce && objReq.wr && objReq.index == vll_pkg::IDX_TRACK_WINDOW) begin
            next_win = objReq.data;
        end else if (ce && objReq.wr && objReq.index == vll_pkg::IDX_PROF_WINDOW) begin
            next_win = {16'h0, objReq.data[15:0]};
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            win <= vll_pkg::RST_TRACK_WINDOW;
        end else begin
            win <= next_win;
        end
    end
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_rsp_valid: assert property (req |=> objRsp.valid)
        else $error("request without answer");
    chk_rsp_quiet: assert property (ce && !req |=> !objRsp.valid)
        else $error("answer without request");
    chk_ro_refused: assert property (
        req && objReq.wr && objReq.index == vll_pkg::IDX_LIMITED_VEL
        |=> objRsp.err && objRsp.data == 32'h0) else $error("read-only write accepted");
    chk_actual_alias: assert property (
        req && !objReq.wr && objReq.index == vll_pkg::IDX_ACTUAL_VEL
        |=> objRsp.data == $past(motorVel)) else $error("actual velocity differs");
    chk_load_object: assert property (
        req && !objReq.wr && objReq.index == vll_pkg::IDX_LOAD_VEL
        |=> objRsp.data == $past(loadVel)) else $error("load velocity differs");
    chk_hold_no_tick: assert property (
        ce && !servoTick |=> $stable(limitedVelocity)) else $error("command moved off tick");
    chk_window_set: assert property (
        ce && absDiff > {1'b0, win} |=> velWindowBit) else $error("window bit not set");
    chk_clear_wait: assert property (
        $rose(velWindowBit) |=> velWindowBit [*4]) else $error("window bit cleared early");
    cover property (req && objReq.wr);
    cover property ($fell(velWindowBit));
    cover property (ce && servoTick && limitedVelocity != 32'sh0);
endmodule // vll_velocity_limiter_monitor
bind vll_velocity_limiter vll_velocity_limiter_monitor mon (.clk, .nrst, .ce, .servoTick,
    .motorVel, .loadVel, .objReq, .objRsp, .limitedVelocity, .velWindowBit);
`default_nettype wire

/* File: test/vll_master_model.sv */
// Network master model issuing object reads and writes
`default_nettype none
module vll_master_model (
    // Clock and answer
    input wire logic clk,
    input wire vll_pkg::vll_obj_rsp_s objRsp,
    // Request
    output var vll_pkg::vll_obj_req_s objReq
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        objReq = '0;
    end
    // Optional idle gap, one-cycle request, answer read a cycle later
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] data,
            input int gap, output vll_pkg::vll_obj_rsp_s rsp);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        objReq = '{wr: wr, rd: !wr, index: idx, data: data};
        @(negedge clk);
        rsp = objRsp;
        // Released index and data lines never keep the last value
        objReq = '{wr: 1'b0, rd: 1'b0, index: ~idx, data: ~data};
    endtask
endmodule // vll_master_model
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the velocity limiter
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, ce, servoTick, stopActive, velWindowBit;
    vll_pkg::vll_src_e cmdSource;
    logic signed [31:0] positionLoopVel, externalVel, motorVel, unfilteredMotorVel, loadVel;
    logic signed [31:0] limitedVelocity;
    logic [31:0] abortAccel, prog;
    vll_pkg::vll_obj_req_s objReq;
    vll_pkg::vll_obj_rsp_s objRsp, rsp;
    int failCount, samplesChecked, cycles, cur, tgt, s, src, st;
    logic [15:0] ri[7] = '{vll_pkg::IDX_MAX_ACCEL, vll_pkg::IDX_MAX_DECEL,
        vll_pkg::IDX_ESTOP_DECEL, vll_pkg::IDX_MAX_LIMIT, vll_pkg::IDX_TRACK_WINDOW,
        vll_pkg::IDX_TRACK_TIME, vll_pkg::IDX_PROG_VEL};
    logic [31:0] rv[7] = '{vll_pkg::RST_MAX_ACCEL, vll_pkg::RST_MAX_DECEL,
        vll_pkg::RST_ESTOP_DECEL, vll_pkg::RST_MAX_LIMIT, vll_pkg::RST_TRACK_WINDOW,
        {16'h0, vll_pkg::RST_TRACK_TIME}, vll_pkg::RST_PROG_VEL};
    vll_velocity_limiter #(.MS_CYCLES(5), .SERVO_RATE_HZ(3000), .FILT_SHIFT(0)) uut (
        .clk, .nrst, .ce, .servoTick, .cmdSource, .stopActive, .positionLoopVel,
        .externalVel, .abortAccel, .motorVel, .unfilteredMotorVel, .loadVel, .objReq,
        .objRsp, .limitedVelocity, .velWindowBit);
    vll_master_model m (.clk, .objRsp, .objReq);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic endOfTest();
        if (failCount == 0 && samplesChecked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samplesChecked++;
        if (g !== e) begin
            failCount++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic wr, input logic [15:0] i, input logic [31:0] d);
        m.access(wr, i, d, int'($urandom % 3), rsp);
        chk("objRsp.valid", 32'h1, {31'h0, rsp.valid});
    endtask
    task automatic rd(input logic [15:0] i, input logic [31:0] e);
        acc(1'b0, i, 32'h0);
        chk($sformatf("object %h", i), e, rsp.data);
    endtask
    // Rate step toward target, then clamp to the limit of 100
    function automatic int nxt(int c, int t, int up, int dn);
        int d;
        int k;
        k = (((t < 0) ? -t : t) > ((c < 0) ? -c : c) || c == 0) ? up : dn;
        d = t - c;
        d = (d > k) ? k : ((d < -k) ? -k : d);
        d = c + d;
        nxt = (d > 100) ? 100 : ((d < -100) ? -100 : d);
    endfunction
    task automatic tick(input int up, input int dn);
        @(negedge clk);
        servoTick = 1'b1;
        @(negedge clk);
        servoTick = 1'b0;
        cur = nxt(cur, tgt, up, dn);
        chk("limitedVelocity", cur, limitedVelocity);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            endOfTest();
        end
    end
    initial begin
        void'($urandom(67));
        {nrst, servoTick, stopActive, positionLoopVel, externalVel} = '0;
        {motorVel, unfilteredMotorVel, loadVel, cur, tgt} = '0;
        ce = 1'b1;
        cmdSource = vll_pkg::VLL_SRC_EXTERNAL;
        abortAccel = 32'hc;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        for (int k = 0; k < 7; k++) rd(ri[k], rv[k]);
        acc(1'b0, 16'h2106, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rsp.err});
        acc(1'b1, vll_pkg::IDX_LIMITED_VEL, 32'h5);
        chk("read-only err", 32'h1, {31'h0, rsp.err});
        acc(1'b1, vll_pkg::IDX_TRACK_WINDOW, 32'h0001_0007);
        rd(vll_pkg::IDX_PROF_WINDOW, 32'h7);
        acc(1'b1, vll_pkg::IDX_PROF_WINDOW, 32'hffff_0005);
        rd(vll_pkg::IDX_TRACK_WINDOW, 32'h5);
        acc(1'b1, vll_pkg::IDX_TRACK_TIME, 32'h2);
        rd(vll_pkg::IDX_PROF_TIME, 32'h2);
        acc(1'b1, vll_pkg::IDX_PROF_TIME, 32'h3);
        rd(vll_pkg::IDX_TRACK_TIME, 32'h3);
        acc(1'b1, vll_pkg::IDX_MAX_ACCEL, 32'h3);
        acc(1'b1, vll_pkg::IDX_MAX_DECEL, 32'h6);
        acc(1'b1, vll_pkg::IDX_ESTOP_DECEL, 32'h9);
        acc(1'b1, vll_pkg::IDX_MAX_LIMIT, 32'h64);
        {motorVel, loadVel, unfilteredMotorVel} = {$urandom, $urandom, $urandom};
        rd(vll_pkg::IDX_ACTUAL_VEL, motorVel);
        rd(vll_pkg::IDX_PRIMARY_VEL, motorVel);
        rd(vll_pkg::IDX_LOAD_VEL, loadVel);
        rd(vll_pkg::IDX_UNFILT_VEL, unfilteredMotorVel);
        for (s = 1; s >= -1; s -= 2) begin
            repeat (40) begin
                src = int'($urandom % 3);
                prog = s * int'($urandom % 151);
                acc(1'b1, vll_pkg::IDX_PROG_VEL, prog);
                positionLoopVel = s * int'($urandom % 151);
                externalVel = s * int'($urandom % 151);
                motorVel = cur + int'($urandom % 13) - 6;
                cmdSource = vll_pkg::vll_src_e'(src);
                tgt = (src == 0) ? externalVel : ((src == 1) ? positionLoopVel : prog);
                tick(10, 20);
            end
            rd(vll_pkg::IDX_LIMITED_VEL, cur);
            cmdSource = (s > 0) ? vll_pkg::VLL_SRC_EXTERNAL : vll_pkg::VLL_SRC_POSITION;
            st = (s > 0) ? 30 : 40;
            stopActive = 1'b1;
            tgt = 0;
            repeat (5) tick(st, st);
            stopActive = 1'b0;
        end
        motorVel = 32'sh6;
        @(negedge clk);
        motorVel = 32'sh0;
        chk("velWindowBit", 32'h1, {31'h0, velWindowBit});
        repeat (13) @(negedge clk);
        chk("velWindowBit", 32'h1, {31'h0, velWindowBit});
        repeat (5) @(negedge clk);
        chk("velWindowBit", 32'h0, {31'h0, velWindowBit});
        endOfTest();
    end
endmodule // tb
`default_nettype wire
